// file: rtl/anr_ability_regs.sv
// Purpose: Local advertisement and partner ability registers for auto-negotiation.
// Assumes: Management accesses arrive decoded, one cycle strobes, on clk.
// Notes:   Strap pins are synchronised and sampled once after reset release.
`timescale 1ns/1ps

// Functional notes
// - Advertisement bit 15 is read/write, reset 0, requests next page exchange.
// - Advertisement bit 11 read/write, reset 0, advertises asymmetric pause.
// - Advertisement bit 10 read/write, reset 0, advertises symmetric pause.
// - Advertisement bit 9, T4 ability, always reads zero.
// - Advertisement bits 8 to 5 select advertised speed and duplex abilities.
// - Basic pin mode seeds bits 8..6 from straps; software and hardware may update.
// - Bit 5 is seeded from its strap in both pin modes.
// - Forced speed and duplex ignores the four ability bits.
// - Selector bits 4..0 are read/write and reset to 00001.
// - Partner register is read-only and resets to zero.
// - Partner bit 15 shows the partner next page request.
// - Partner bit 14 shows the partner acknowledge.
// - Partner bit 13 shows the partner remote fault.
// - Partner bits 11 and 10 show partner asymmetric and symmetric pause.
// - Partner bit 9 shows partner T4 ability.
// - Partner bits 8..5 show partner speed and duplex abilities.
// - Partner bits 4..0 hold the received selector field.
// - Advertisement sits at offset 4h, reset value ends in 1h.
module anr_ability_regs
  import anr_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire anr_mgmt_req_s mgmtReq,
  output logic [15:0]        mgmtRdata,
  output logic               mgmtRvalid,
  input  wire logic          basicMode,
  input  wire anr_strap_s    strapPins,
  input  wire logic          forcedMode,
  input  wire logic          hwAbilityWrite,
  input  wire logic [3:0]    hwAbility,
  input  wire logic          pageReceived,
  input  wire logic [15:0]   rxCodeWord,
  output logic [15:0]        txCodeWord
);

  logic [15:0] localAdv;
  logic [15:0] partnerAbility;
  anr_strap_s  strapMeta;
  anr_strap_s  strapSync;
  logic        basicMeta;
  logic        basicSync;
  logic [1:0]  strapCount;
  logic        strapLoad;
  logic        advWrite;
  logic [15:0] next_localAdv;

  // Straps come from pins, so they pass two flip-flops before use.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strapMeta <= '0;
      strapSync <= '0;
      basicMeta <= 1'b0;
      basicSync <= 1'b0;
    end else begin
      strapMeta <= strapPins;
      strapSync <= strapMeta;
      basicMeta <= basicMode;
      basicSync <= basicMeta;
    end
  end

  // Wait for the synchroniser to fill, then take the straps once.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strapCount <= 2'h0;
    end else if (strapCount != 2'h3) begin
      strapCount <= strapCount + 2'h1;
    end
  end

  assign strapLoad = (strapCount == 2'h2);
  assign advWrite  = mgmtReq.write && (mgmtReq.addr == ADDR_LOCAL_ADV);

  // Software writes win over hardware updates; read-only bits are masked off.
  always_comb begin
    next_localAdv = localAdv;
    if (strapLoad) begin
      if (basicSync) begin
        next_localAdv[BIT_TX_FULL] = strapSync.txFull;
        next_localAdv[BIT_TX_HALF] = strapSync.txHalf;
        next_localAdv[BIT_T_FULL]  = strapSync.tFull;
      end
      next_localAdv[BIT_T_HALF] = strapSync.tHalf;
    end
    if (hwAbilityWrite) begin
      next_localAdv[BIT_TX_FULL:BIT_T_HALF] = hwAbility;
    end
    if (advWrite) begin
      // Remote fault bit 13 is stored as written; software must keep it 0.
      next_localAdv = mgmtReq.wdata & LOCAL_WRITE_MASK;
    end
    next_localAdv[BIT_T4]      = 1'b0;
    next_localAdv[BIT_RSVD_HI] = 1'b0;
    next_localAdv[BIT_RSVD_LO] = 1'b0;
  end

  // Until the straps are taken the ability bits read zero.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      localAdv <= {11'h000, SELECTOR_IEEE};
    end else begin
      localAdv <= next_localAdv;
    end
  end

  // Partner word is captured only on a received base page, one field to a line.
  // Reserved bit 12 is passed through as sent, so an odd partner stays visible to software.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      partnerAbility <= PARTNER_RESET;
    end else if (pageReceived) begin
      // Link control bits come first.
      partnerAbility[BIT_NEXT_PAGE] <= rxCodeWord[BIT_NEXT_PAGE];
      partnerAbility[BIT_ACK] <= rxCodeWord[BIT_ACK];
      partnerAbility[BIT_REMOTE_FAULT] <= rxCodeWord[BIT_REMOTE_FAULT];
      partnerAbility[BIT_RSVD_LO] <= rxCodeWord[BIT_RSVD_LO];
      // Pause, technology abilities and the selector follow.
      partnerAbility[BIT_ASYM_PAUSE] <= rxCodeWord[BIT_ASYM_PAUSE];
      partnerAbility[BIT_SYM_PAUSE] <= rxCodeWord[BIT_SYM_PAUSE];
      partnerAbility[BIT_T4] <= rxCodeWord[BIT_T4];
      partnerAbility[BIT_TX_FULL:BIT_T_HALF] <= rxCodeWord[BIT_TX_FULL:BIT_T_HALF];
      partnerAbility[BIT_SEL_HI:0] <= rxCodeWord[BIT_SEL_HI:0];
    end
  end

  // Forced mode blanks the speed and duplex bits on the wire, not in the register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txCodeWord <= 16'h0000;
    end else begin
      txCodeWord <= localAdv;
      if (forcedMode) begin
        txCodeWord[BIT_TX_FULL:BIT_T_HALF] <= 4'h0;
      end
    end
  end

  // Read data is registered; unmapped offsets read as zero.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mgmtRdata  <= 16'h0000;
      mgmtRvalid <= 1'b0;
    end else begin
      mgmtRvalid <= mgmtReq.read;
      if (mgmtReq.read) begin
        unique case (mgmtReq.addr)
          ADDR_LOCAL_ADV: mgmtRdata <= localAdv;
          ADDR_PARTNER:   mgmtRdata <= partnerAbility;
          default:        mgmtRdata <= 16'h0000;
        endcase
      end
    end
  end

  // The checks below watch only what this block drives, and rest while reset is high.
  // Rules that bind the management host are kept by the bench, not checked here.
  // Edge-relative checks use one-cycle implication, matching the registered outputs; the two reset-release checks use |-> instead.

  // Read-only advertisement bits never come up set.
  a_t4_zero: assert property (@(posedge clk) disable iff (reset)
    !localAdv[BIT_T4] && !localAdv[BIT_RSVD_HI] && !localAdv[BIT_RSVD_LO])
    else $error("Advertisement read-only bit is set.");

  // Upper advertisement bits follow a software write, minus the read-only ones.
  a_adv_write: assert property (@(posedge clk) disable iff (reset)
    advWrite |=> localAdv[15:10] == ($past(mgmtReq.wdata[15:10]) & LOCAL_WRITE_MASK[15:10]))
    else $error("Advertisement upper write not stored.");

  // The selector field takes whatever software writes.
  a_selector_write: assert property (@(posedge clk) disable iff (reset)
    advWrite |=> localAdv[BIT_SEL_HI:0] == $past(mgmtReq.wdata[BIT_SEL_HI:0]))
    else $error("Selector write not stored.");

  // The four ability bits take a software write as it stands.
  a_ability_write: assert property (@(posedge clk) disable iff (reset)
    advWrite |=>
      localAdv[BIT_TX_FULL:BIT_T_HALF] == $past(mgmtReq.wdata[BIT_TX_FULL:BIT_T_HALF]))
    else $error("Ability write not stored.");

  // A hardware ability update lands unless software writes in the same cycle.
  a_hw_update: assert property (@(posedge clk) disable iff (reset)
    hwAbilityWrite && !advWrite |=> localAdv[BIT_TX_FULL:BIT_T_HALF] == $past(hwAbility))
    else $error("Hardware ability update not stored.");

  // Software wins over a hardware update that falls in the same cycle.
  a_sw_over_hw: assert property (@(posedge clk) disable iff (reset)
    advWrite && hwAbilityWrite |=>
      localAdv[BIT_TX_FULL:BIT_T_HALF] == $past(mgmtReq.wdata[BIT_TX_FULL:BIT_T_HALF]))
    else $error("Hardware update beat a software write.");

  // In basic pin mode the three upper ability bits take their straps.
  a_strap_basic: assert property (@(posedge clk) disable iff (reset)
    strapLoad && basicSync && !advWrite && !hwAbilityWrite |=>
      localAdv[BIT_TX_FULL:BIT_T_FULL] ==
        $past({strapSync.txFull, strapSync.txHalf, strapSync.tFull}))
    else $error("Basic mode straps not taken.");

  // In enhanced pin mode the strap load leaves the three upper ability bits alone.
  a_strap_enh: assert property (@(posedge clk) disable iff (reset)
    strapLoad && !basicSync && !advWrite && !hwAbilityWrite |=>
      $stable(localAdv[BIT_TX_FULL:BIT_T_FULL]))
    else $error("Enhanced mode took upper straps.");

  // The half-duplex strap is taken in both pin modes.
  a_strap_half: assert property (@(posedge clk) disable iff (reset)
    strapLoad && !advWrite && !hwAbilityWrite |=>
      localAdv[BIT_T_HALF] == $past(strapSync.tHalf))
    else $error("Half-duplex strap not taken.");

  // Straps are taken at the third edge after release, once the synchroniser is full.
  a_strap_time: assert property (@(posedge clk) disable iff (reset)
    $fell(reset) |-> ##2 strapLoad)
    else $error("Strap load not at the expected edge.");

  // The straps are taken once per reset; later edges never reload them.
  a_strap_once: assert property (@(posedge clk) disable iff (reset)
    strapLoad |=> !strapLoad [*8])
    else $error("Straps taken more than once.");

  // With no write, hardware update or strap load the advertisement holds its value.
  a_adv_hold: assert property (@(posedge clk) disable iff (reset)
    !advWrite && !hwAbilityWrite && !strapLoad |=> $stable(localAdv))
    else $error("Advertisement changed on its own.");

  // Forced mode leaves the stored ability bits as they are.
  a_forced_keep: assert property (@(posedge clk) disable iff (reset)
    forcedMode && !advWrite && !hwAbilityWrite && !strapLoad |=>
      $stable(localAdv[BIT_TX_FULL:BIT_T_HALF]))
    else $error("Forced mode altered stored abilities.");

  // A received page lands whole in the partner register.
  a_partner_load: assert property (@(posedge clk) disable iff (reset)
    pageReceived |=> partnerAbility == $past(rxCodeWord))
    else $error("Partner page not captured.");

  // Without a page the partner register keeps its word.
  a_partner_hold: assert property (@(posedge clk) disable iff (reset)
    !pageReceived |=> $stable(partnerAbility))
    else $error("Partner register changed without a page.");

  // Right after reset release both registers still hold their reset words.
  a_reset_values: assert property (@(posedge clk) disable iff (reset)
    $fell(reset) |-> partnerAbility == PARTNER_RESET &&
      localAdv == {11'h000, SELECTOR_IEEE})
    else $error("Register reset word wrong after release.");

  // Forced mode sends the ability bits as zero.
  a_forced_blank: assert property (@(posedge clk) disable iff (reset)
    forcedMode |=> txCodeWord[BIT_TX_FULL:BIT_T_HALF] == 4'h0)
    else $error("Forced mode sent ability bits.");

  // Outside forced mode the code word is the advertisement one cycle late.
  a_tx_follow: assert property (@(posedge clk) disable iff (reset)
    !forcedMode |=> txCodeWord == $past(localAdv))
    else $error("Code word does not follow advertisement.");

  // Reserved and T4 positions are zero on the wire as well.
  a_tx_reserved: assert property (@(posedge clk) disable iff (reset)
    !txCodeWord[BIT_T4] && !txCodeWord[BIT_RSVD_HI] && !txCodeWord[BIT_RSVD_LO])
    else $error("Code word reserved bit is set.");

  // An advertisement read answers one cycle later with the stored word.
  a_read_adv: assert property (@(posedge clk) disable iff (reset)
    mgmtReq.read && mgmtReq.addr == ADDR_LOCAL_ADV |=>
      mgmtRvalid && mgmtRdata == $past(localAdv))
    else $error("Advertisement read returned wrong data.");

  // A partner read answers one cycle later with the captured word.
  a_read_partner: assert property (@(posedge clk) disable iff (reset)
    mgmtReq.read && mgmtReq.addr == ADDR_PARTNER |=>
      mgmtRvalid && mgmtRdata == $past(partnerAbility))
    else $error("Partner read returned wrong data.");

  // Offsets outside the two registers read as zero.
  a_read_unmapped: assert property (@(posedge clk) disable iff (reset)
    mgmtReq.read && mgmtReq.addr != ADDR_LOCAL_ADV && mgmtReq.addr != ADDR_PARTNER |=>
      mgmtRdata == 16'h0000)
    else $error("Unmapped offset did not read zero.");

  // Every read strobe is answered in the next cycle.
  a_rvalid_read: assert property (@(posedge clk) disable iff (reset)
    mgmtReq.read |=> mgmtRvalid)
    else $error("Read not answered.");

  // The answer flag never rises without a read strobe.
  a_rvalid_pulse: assert property (@(posedge clk) disable iff (reset)
    !mgmtReq.read |=> !mgmtRvalid)
    else $error("Answer flag without a read.");

  // Read data holds until the next read.
  a_rdata_hold: assert property (@(posedge clk) disable iff (reset)
    !mgmtReq.read |=> $stable(mgmtRdata))
    else $error("Read data changed without a read.");

endmodule : anr_ability_regs

// file: rtl/anr_pkg.sv
// Purpose: Shared constants and carriers for the auto-negotiation ability registers.
// Assumes: 16-bit management registers addressed by a 5-bit register index.
// Notes:   Offsets are register indices on the serial management interface.
package anr_pkg;

  localparam logic [4:0]  ADDR_LOCAL_ADV     = 5'h04;
  localparam logic [4:0]  ADDR_PARTNER       = 5'h05;
  localparam int          BIT_NEXT_PAGE      = 15;
  localparam int          BIT_ACK            = 14;
  localparam int          BIT_REMOTE_FAULT   = 13;
  localparam int          BIT_RSVD_HI        = 14;
  localparam int          BIT_RSVD_LO        = 12;
  localparam int          BIT_ASYM_PAUSE     = 11;
  localparam int          BIT_SYM_PAUSE      = 10;
  localparam int          BIT_T4             = 9;
  localparam int          BIT_TX_FULL        = 8;
  localparam int          BIT_TX_HALF        = 7;
  localparam int          BIT_T_FULL         = 6;
  localparam int          BIT_T_HALF         = 5;
  localparam int          BIT_SEL_HI         = 4;
  localparam logic [4:0]  SELECTOR_IEEE      = 5'h01;
  localparam logic [15:0] PARTNER_RESET      = 16'h0000;
  // Writable bits of the advertisement word: 15, 13, 11, 10, 8..0.
  localparam logic [15:0] LOCAL_WRITE_MASK   = 16'hADFF;

  // One management access as seen by the register bank.
  typedef struct packed {
    logic        write;
    logic        read;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } anr_mgmt_req_s;

  // Strap levels that seed the speed and duplex ability bits.
  typedef struct packed {
    logic txFull;
    logic txHalf;
    logic tFull;
    logic tHalf;
  } anr_strap_s;

endpackage : anr_pkg

// file: tb/anr_host_model.sv
// Purpose: Station management host model that issues register reads and writes.
// Assumes: One-cycle access strobes; the answer to a read is flagged by mgmtRvalid.
// Notes:   Drives on the falling edge so the block always samples settled values.
`timescale 1ns/1ps
module anr_host_model
  import anr_pkg::*;
(
  input  wire logic          clk,
  output anr_mgmt_req_s      mgmtReq,
  input  wire logic [15:0]   mgmtRdata,
  input  wire logic          mgmtRvalid
);
  initial mgmtReq = '0;
  logic seenValid; // Answer flag level seen by the last read.

  // Remote fault is always cleared here, because the device cannot back it up.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    mgmtReq <= '{1'b1, 1'b0, a, d & 16'hDFFF};
    @(negedge clk);
    mgmtReq <= '0;
    @(negedge clk);
  endtask : wr

  // The wait is bounded so a missing answer shows up as bad data, not a hang.
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int n;
    mgmtReq <= '{1'b0, 1'b1, a, 16'h0000};
    @(negedge clk);
    mgmtReq <= '0;
    for (n = 0; n < 4 && mgmtRvalid !== 1'b1; n++) @(negedge clk);
    seenValid = mgmtRvalid;
    d = mgmtRdata;
    @(negedge clk);
  endtask : rd
endmodule : anr_host_model

// file: tb/anr_ability_regs_test.sv
// Purpose: Self-checking bench for the auto-negotiation ability registers.
// Assumes: Straps held stable from reset until they are latched.
// Notes:   Expected words are written out as hex constants, never read back first.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module anr_ability_regs_test
  import anr_pkg::*;
;
  logic clk = 1'b0, reset = 1'b1, basicMode = 1'b1, forcedMode = 1'b0;
  logic hwAbilityWrite = 1'b0, pageReceived = 1'b0;
  logic [3:0] hwAbility = 4'h0;
  logic [15:0] rxCodeWord = 16'h0000, mgmtRdata, txCodeWord, d;
  logic mgmtRvalid;
  anr_strap_s strapPins = '{1'b1, 1'b0, 1'b1, 1'b0};
  anr_mgmt_req_s mgmtReq;
  int error_cnt = 0, check_count = 0;

  always #2.5 clk = ~clk;

  anr_ability_regs anr_ability_regs_i (.clk(clk), .reset(reset), .mgmtReq(mgmtReq),
    .mgmtRdata(mgmtRdata), .mgmtRvalid(mgmtRvalid), .basicMode(basicMode),
    .strapPins(strapPins), .forcedMode(forcedMode), .hwAbilityWrite(hwAbilityWrite),
    .hwAbility(hwAbility), .pageReceived(pageReceived), .rxCodeWord(rxCodeWord),
    .txCodeWord(txCodeWord));
  anr_host_model anr_host_model_i (.clk(clk), .mgmtReq(mgmtReq), .mgmtRdata(mgmtRdata),
    .mgmtRvalid(mgmtRvalid));

  // One pulse of a single-cycle sideband strobe, launched on a falling edge.
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    @(negedge clk);
  endtask : pulse

  // Straps 1010 land in bits 8..5 on top of the reset selector.
  task automatic t_reset_values();
    anr_host_model_i.rd(ADDR_LOCAL_ADV, d);
    `CHK(d, 16'h0141)
    `CHK(anr_host_model_i.seenValid, 1'b1)
    anr_host_model_i.rd(ADDR_PARTNER, d);
    `CHK(d, 16'h0000)
  endtask : t_reset_values

  // All-ones write: reserved and T4 bits must stay clear.
  task automatic t_write_all();
    anr_host_model_i.wr(ADDR_LOCAL_ADV, 16'hFFFF);
    anr_host_model_i.rd(ADDR_LOCAL_ADV, d);
    `CHK(d, 16'h8DFF)
    `CHK(txCodeWord, 16'h8DFF)
  endtask : t_write_all

  // Forced mode hides abilities on the wire; a hardware update still lands.
  task automatic t_forced_hw();
    forcedMode <= 1'b1;
    @(negedge clk);
    @(negedge clk);
    `CHK(txCodeWord, 16'h8C1F)
    hwAbility <= 4'h5;
    pulse(hwAbilityWrite);
    forcedMode <= 1'b0;
    anr_host_model_i.rd(ADDR_LOCAL_ADV, d);
    `CHK(d, 16'h8CBF)
  endtask : t_forced_hw

  // Partner word is loaded only by a received page; host writes are refused.
  task automatic t_partner();
    anr_host_model_i.wr(ADDR_PARTNER, 16'h1234);
    anr_host_model_i.rd(ADDR_PARTNER, d);
    `CHK(d, 16'h0000)
    rxCodeWord <= 16'hEFE1;
    pulse(pageReceived);
    anr_host_model_i.rd(ADDR_PARTNER, d);
    `CHK(d, 16'hEFE1)
  endtask : t_partner

  // Selector is writable; unmapped offsets read zero.
  task automatic t_selector();
    anr_host_model_i.wr(ADDR_LOCAL_ADV, 16'h0000);
    anr_host_model_i.rd(ADDR_LOCAL_ADV, d);
    `CHK(d, 16'h0000)
    anr_host_model_i.rd(5'h07, d);
    `CHK(d, 16'h0000)
  endtask : t_selector

  // Second reset in enhanced pin mode: only the half-duplex strap seeds the word.
  task automatic t_enhanced();
    basicMode <= 1'b0;
    strapPins <= '{1'b1, 1'b1, 1'b1, 1'b1};
    reset <= 1'b1;
    repeat (3) @(negedge clk);
    reset <= 1'b0;
    repeat (5) @(negedge clk);
    `CHK(txCodeWord, 16'h0021)
    anr_host_model_i.rd(ADDR_LOCAL_ADV, d);
    `CHK(d, 16'h0021)
    anr_host_model_i.rd(ADDR_PARTNER, d);
    `CHK(d, 16'h0000)
  endtask : t_enhanced

  task automatic conclude();
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // The whole sequence needs under fifty cycles; the limit of 2000 cycles is generous.
  initial begin
    #(2000 * 5);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (3) @(negedge clk);
    reset <= 1'b0;
    repeat (5) @(negedge clk);
    t_reset_values();
    t_write_all();
    t_forced_hw();
    t_partner();
    t_selector();
    t_enhanced();
    conclude();
  end
endmodule : anr_ability_regs_test
